// >>> hw/coec_core.sv
/*
  Complementary output event control: APB registers, event source
  selection, phase delay, blanking, dead-band and output mapping.
  Assumes an APB master on pclk, asynchronous event and oscillator pins,
  and an external pin-level resolver for the output enables.
*/
// What this block does
// R1 - Delay timers tick from oscillator, instruction clock or system clock.
// R2 - That tick times counter dead-band, blanking and phase-delay timers.
// R3 - Rising event is the OR of all enabled rising sources.
// R4 - Falling event is the OR of enabled falling sources, independently.
// R5 - Each source is edge sensed when its kind bit is one, else level.
// R6 - Software should pick edge for periodic, level for threshold sources.
// R7 - Rising event assertion starts the active duty period.
// R8 - Zero rising phase and dead-band drive primary at once.
// R9 - Rising event runs phase delay, clears complement, blanks, dead-band.
// R10 - Falling event assertion ends the active duty period.
// R11 - Falling event runs phase delay, clears primary, blanks, dead-band.
// R12 - Zero falling phase and dead-band drive complement at once.
// R13 - Disabled or just enabled: primary inactive, complement active.
// R14 - Steered modes: static data, override, inactive or PWM per steer bit.
// R15 - Other modes ignore steering: override, PWM when enabled, else inactive.
// R16 - Each output inverts when its polarity bit is one.
// R17 - Only the inactive override choice honours polarity.
// R18 - Dead-band acts only in half-bridge and on bridge direction change.
// R19 - Two dead-band timers, each chain or counter by its select bit.
// R20 - Half-bridge holds first and third off for rising dead-band.
// R21 - Half-bridge holds second and fourth off for falling dead-band.
// R22 - Bridge change delays modulated output by falling or rising dead-band.
// R23 - Mode field decodes steered, sync steered, bridges, half, push-pull.
// R24 - Forward modulates fourth, first on; reverse modulates second, third on.
// R25 - Counter dead-band counts delay ticks to the count; zero disables it.
// R26 - Chain dead-band delays by count elements of a fixed nominal delay.
// R27 - Sources are synchronised before detection so each edge pulses once.
`timescale 1ns/1ps
`default_nettype none

`include "coec_defines.svh"

module coec_core (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic [15:0] event_source,
  input  wire logic        fast_internal_oscillator,
  input  wire logic        shutdown_request,
  output var  logic        drive_out_first,
  output var  logic        drive_out_second,
  output var  logic        drive_out_third,
  output var  logic        drive_out_fourth,
  output var  logic [3:0]  drive_out_oe_n
);

  // Edge or level sense of every source; high_active picks the sensed level.
  function automatic logic [15:0] detect(input logic [15:0] now, input logic [15:0] prev,
                                         input logic [15:0] kind, input logic high_active);
    logic [15:0] lvl;
    logic [15:0] edg;
    lvl = high_active ? now : ~now;
    edg = high_active ? (now & ~prev) : (~now & prev);
    detect = (kind & edg) | (~kind & lvl);
  endfunction : detect

  // Dead-band limit in delay ticks; chain elements are rounded up to cycles.
  function automatic logic [7:0] db_limit(input logic [7:0] n, input logic chain);
    logic [15:0] ns;
    ns = 16'(n) * 16'(`COEC_ELEMENT_NS);
    if (!chain || n == 8'h00) begin
      db_limit = n;
    end else begin
      db_limit = 8'((ns + 16'(`COEC_CLK_NS) - 16'h0001) / 16'(`COEC_CLK_NS));
    end
  endfunction : db_limit

  logic [7:0]  cfg [0:`COEC_NUM_RW-1];
  logic [7:0]  next_cfg [0:`COEC_NUM_RW-1];
  logic [31:0] next_prdata;
  logic [4:0]  idx;
  logic        mapped;
  logic [7:0]  status;

  logic [15:0] src_s1;
  logic [15:0] src_s2;
  logic [15:0] src_s3;
  logic        osc_s1;
  logic        osc_s2;
  logic        osc_s3;
  logic        sd_s1;
  logic        sd_s2;
  logic [1:0]  div;
  logic [1:0]  next_div;

  logic        rise_sig_q;
  logic        fall_sig_q;
  logic        pri;
  logic        comp;
  logic        pp_sel;
  logic [3:0]  steer_act;
  logic [2:0]  mode_q;
  logic [3:0]  out_q;
  logic        next_rise_sig_q;
  logic        next_fall_sig_q;
  logic        next_pri;
  logic        next_comp;
  logic        next_pp_sel;
  logic [3:0]  next_steer_act;
  logic [2:0]  next_mode_q;
  logic [3:0]  next_out_q;
  logic [3:0]  next_oe_n;

  coec_pkg::coec_mode_t     mode;
  coec_pkg::coec_clk_sel_t  clk_sel;
  coec_pkg::coec_override_t ovr;
  logic        en;
  logic        sd;
  logic        tick;
  logic        half;
  logic        rise_sig;
  logic        fall_sig;
  logic        rise_trig;
  logic        fall_trig;
  logic        rise_go;
  logic        fall_go;
  logic        to_fwd;
  logic        to_rev;
  logic        bridge_hold;
  logic [7:0]  dbr_lim;
  logic [7:0]  dbf_lim;
  logic [3:0]  pwm;
  logic [3:0]  pol;
  logic [3:0]  steer_data;

  coec_timer_if tmr [`COEC_TMR_COUNT] ();

  for (genvar g = 0; g < `COEC_TMR_COUNT; g++) begin : g_tmr
    coec_delay_timer u_tmr (
      .pclk    (pclk),
      .presetn (presetn),
      .tmr     (tmr[g])
    );
  end

  // Register bus: zero wait states, unmapped words answer with an error.
  assign idx     = paddr[6:2];
  assign mapped  = (paddr[7] == 1'b0) && (paddr[1:0] == 2'h0) && (idx <= `COEC_IDX_STATUS);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  assign status = {pp_sel, sd, comp, pri, out_q};

  always_comb begin
    for (int i = 0; i < `COEC_NUM_RW; i++) begin
      next_cfg[i] = cfg[i];
    end
    next_prdata = prdata;
    if (psel && penable && pwrite && mapped && idx != `COEC_IDX_STATUS) begin
      next_cfg[idx] = pwdata[7:0];
    end
    // Read data is captured in the setup cycle so it stands through access.
    if (psel && !penable) begin
      next_prdata = 32'h0000_0000;
      if (mapped && idx == `COEC_IDX_STATUS) begin
        next_prdata[7:0] = status;
      end else if (mapped) begin
        next_prdata[7:0] = cfg[idx];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `COEC_NUM_RW; i++) begin
        cfg[i] <= `COEC_REG_RESET;
      end
      prdata <= 32'h0000_0000;
    end else begin
      for (int i = 0; i < `COEC_NUM_RW; i++) begin
        cfg[i] <= next_cfg[i];
      end
      prdata <= next_prdata;
    end
  end

  // Control decode.
  assign en         = cfg[`COEC_IDX_CTL0][`COEC_CTL0_EN];
  assign mode       = coec_pkg::coec_mode_t'(cfg[`COEC_IDX_CTL0][`COEC_CTL0_MODE_LSB +: 3]);
  assign clk_sel    = coec_pkg::coec_clk_sel_t'(cfg[`COEC_IDX_CTL0][`COEC_CTL0_CS_LSB +: 2]);
  assign ovr        = coec_pkg::coec_override_t'(cfg[`COEC_IDX_SHUT][`COEC_SHUT_OVR_LSB +: 2]);
  assign pol        = cfg[`COEC_IDX_CTL1][3:0];
  assign steer_data = cfg[`COEC_IDX_STEER][`COEC_STEER_DATA_LSB +: 4];
  assign sd         = sd_s2 || cfg[`COEC_IDX_SHUT][`COEC_SHUT_SW];
  // R23 mode decode
  assign half       = (mode == coec_pkg::mode_half);

  // R27 source synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_s1 <= 16'h0000;
      src_s2 <= 16'h0000;
      src_s3 <= 16'h0000;
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_s3 <= 1'b0;
      sd_s1  <= 1'b0;
      sd_s2  <= 1'b0;
      div    <= 2'h0;
    end else begin
      src_s1 <= event_source;
      src_s2 <= src_s1;
      src_s3 <= src_s2;
      osc_s1 <= fast_internal_oscillator;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
      sd_s1  <= shutdown_request;
      sd_s2  <= sd_s1;
      div    <= next_div;
    end
  end

  // R1 delay timebase select
  always_comb begin
    next_div = div + 2'h1;
    case (clk_sel)
      coec_pkg::clk_fast_osc: tick = osc_s2 && !osc_s3;
      coec_pkg::clk_instr:    tick = (div == `COEC_INSTR_LAST);
      default:                tick = 1'b1;
    endcase
  end

  // R3 rising sources ORed, R5 edge or level
  assign rise_sig = |({cfg[`COEC_IDX_RIS_HI], cfg[`COEC_IDX_RIS_LO]} &
                      detect(src_s2, src_s3,
                             {cfg[`COEC_IDX_RSIM_HI], cfg[`COEC_IDX_RSIM_LO]}, 1'b1));
  // R4 falling sources ORed, R5 edge or level
  assign fall_sig = |({cfg[`COEC_IDX_FIS_HI], cfg[`COEC_IDX_FIS_LO]} &
                      detect(src_s2, src_s3,
                             {cfg[`COEC_IDX_FSIM_HI], cfg[`COEC_IDX_FSIM_LO]}, 1'b0));

  // R7 rising assertion, gated by blanking
  assign rise_trig = en && rise_sig && !rise_sig_q && !tmr[`COEC_TMR_BLKF].busy;
  // R10 falling assertion, gated by blanking
  assign fall_trig = en && fall_sig && !fall_sig_q && !tmr[`COEC_TMR_BLKR].busy;

  // R2 shared timebase for phase and blanking timers
  assign tmr[`COEC_TMR_PHR].tick  = tick;
  assign tmr[`COEC_TMR_PHF].tick  = tick;
  assign tmr[`COEC_TMR_BLKR].tick = tick;
  assign tmr[`COEC_TMR_BLKF].tick = tick;
  // R19 chain or counter per dead-band timer
  assign tmr[`COEC_TMR_DBR].tick  = cfg[`COEC_IDX_CTL0][`COEC_CTL0_RISE_DEADTIME_CHAIN_SEL] || tick;
  assign tmr[`COEC_TMR_DBF].tick  = cfg[`COEC_IDX_CTL0][`COEC_CTL0_FALL_DEADTIME_CHAIN_SEL] || tick;

  // R26 chain length, R25 counter length
  assign dbr_lim = db_limit(cfg[`COEC_IDX_DBR], cfg[`COEC_IDX_CTL0][`COEC_CTL0_RISE_DEADTIME_CHAIN_SEL]);
  assign dbf_lim = db_limit(cfg[`COEC_IDX_DBF], cfg[`COEC_IDX_CTL0][`COEC_CTL0_FALL_DEADTIME_CHAIN_SEL]);

  assign tmr[`COEC_TMR_PHR].limit  = cfg[`COEC_IDX_PHR];
  assign tmr[`COEC_TMR_PHF].limit  = cfg[`COEC_IDX_PHF];
  assign tmr[`COEC_TMR_BLKR].limit = cfg[`COEC_IDX_BLKR];
  assign tmr[`COEC_TMR_BLKF].limit = cfg[`COEC_IDX_BLKF];
  assign tmr[`COEC_TMR_DBR].limit  = dbr_lim;
  assign tmr[`COEC_TMR_DBF].limit  = dbf_lim;

  // R9 rising phase delay
  assign tmr[`COEC_TMR_PHR].start = rise_trig;
  assign tmr[`COEC_TMR_PHR].stop  = !en;
  // R11 falling phase delay
  assign tmr[`COEC_TMR_PHF].start = fall_trig;
  assign tmr[`COEC_TMR_PHF].stop  = !en;

  assign rise_go = (rise_trig && cfg[`COEC_IDX_PHR] == 8'h00) || tmr[`COEC_TMR_PHR].done;
  assign fall_go = (fall_trig && cfg[`COEC_IDX_PHF] == 8'h00) || tmr[`COEC_TMR_PHF].done;

  // R9 blank falling inputs
  assign tmr[`COEC_TMR_BLKR].start = rise_go;
  assign tmr[`COEC_TMR_BLKR].stop  = !en;
  // R11 blank rising inputs
  assign tmr[`COEC_TMR_BLKF].start = fall_go;
  assign tmr[`COEC_TMR_BLKF].stop  = !en;

  // R22 bridge direction changes
  assign to_fwd = en && mode == coec_pkg::mode_full_fwd &&
                  mode_q == 3'(coec_pkg::mode_full_rev);
  assign to_rev = en && mode == coec_pkg::mode_full_rev &&
                  mode_q == 3'(coec_pkg::mode_full_fwd);

  // R18 dead-band only in half-bridge or on direction change
  assign tmr[`COEC_TMR_DBR].start = (half && rise_go) || to_fwd;
  assign tmr[`COEC_TMR_DBF].start = (half && fall_go) || to_rev;
  // Overlap: a new opposite event cuts the running dead-band short and extends.
  assign tmr[`COEC_TMR_DBR].stop  = !en || (half && fall_go);
  assign tmr[`COEC_TMR_DBF].stop  = !en || (half && rise_go);

  // The change cycle itself holds too, so the modulated output never leaks one cycle early.
  assign bridge_hold = tmr[`COEC_TMR_DBR].busy || tmr[`COEC_TMR_DBF].busy || to_fwd || to_rev;

  // Primary and complementary drive.
  always_comb begin
    next_rise_sig_q = rise_sig;
    next_fall_sig_q = fall_sig;
    next_pri        = pri;
    next_comp       = comp;
    next_pp_sel     = pp_sel;
    next_steer_act  = steer_act;
    next_mode_q     = mode;
    if (!en) begin
      // R13 idle drive
      next_pri  = 1'b0;
      next_comp = 1'b1;
    end else begin
      // R20 primary after rising dead-band
      if (half && tmr[`COEC_TMR_DBR].done) begin
        next_pri = 1'b1;
      end
      // R21 complement after falling dead-band
      if (half && tmr[`COEC_TMR_DBF].done) begin
        next_comp = 1'b1;
      end
      if (rise_go) begin
        // R9 clear complement
        next_comp   = 1'b0;
        // R8 immediate primary
        next_pri    = !(half && dbr_lim != 8'h00);
        next_pp_sel = !pp_sel;
      end
      if (fall_go) begin
        // R11 clear primary
        next_pri  = 1'b0;
        // R12 immediate complement
        next_comp = !(half && dbf_lim != 8'h00);
      end
    end
    // R14 steering takes effect at once or on a rising event
    if (mode != coec_pkg::mode_sync_steer || rise_go) begin
      next_steer_act = cfg[`COEC_IDX_STEER][3:0];
    end
  end

  // R24 per-mode output waveforms
  always_comb begin
    case (mode)
      coec_pkg::mode_steer,
      coec_pkg::mode_sync_steer: pwm = {4{pri}};
      coec_pkg::mode_full_fwd:   pwm = {pri && !bridge_hold, 2'b00, 1'b1};
      coec_pkg::mode_full_rev:   pwm = {1'b0, 1'b1, pri && !bridge_hold, 1'b0};
      coec_pkg::mode_half:       pwm = {comp, pri, comp, pri};
      coec_pkg::mode_push_pull:  pwm = {pri && pp_sel, pri && !pp_sel,
                                        pri && pp_sel, pri && !pp_sel};
      default:                   pwm = 4'h0;
    endcase
  end

  always_comb begin
    next_out_q = 4'h0;
    next_oe_n  = 4'h0;
    for (int i = 0; i < 4; i++) begin
      if (sd) begin
        // R17 polarity only in the inactive override
        case (ovr)
          coec_pkg::ovr_inactive: next_out_q[i] = pol[i];
          coec_pkg::ovr_float:    next_oe_n[i]  = 1'b1;
          coec_pkg::ovr_low:      next_out_q[i] = 1'b0;
          default:                next_out_q[i] = 1'b1;
        endcase
      end else if ((mode == coec_pkg::mode_steer || mode == coec_pkg::mode_sync_steer)
                   && !steer_act[i]) begin
        // R14 static steering data
        next_out_q[i] = steer_data[i] ^ pol[i];
      end else begin
        // R15 PWM when enabled, R16 polarity
        next_out_q[i] = (en && pwm[i]) ^ pol[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rise_sig_q     <= 1'b0;
      fall_sig_q     <= 1'b0;
      pri            <= 1'b0;
      comp           <= 1'b1;
      pp_sel         <= 1'b0;
      steer_act      <= 4'h0;
      mode_q         <= 3'h0;
      out_q          <= 4'h0;
      drive_out_oe_n <= 4'h0;
    end else begin
      rise_sig_q     <= next_rise_sig_q;
      fall_sig_q     <= next_fall_sig_q;
      pri            <= next_pri;
      comp           <= next_comp;
      pp_sel         <= next_pp_sel;
      steer_act      <= next_steer_act;
      mode_q         <= next_mode_q;
      out_q          <= next_out_q;
      drive_out_oe_n <= next_oe_n;
    end
  end

  assign drive_out_first  = out_q[0];
  assign drive_out_second = out_q[1];
  assign drive_out_third  = out_q[2];
  assign drive_out_fourth = out_q[3];

endmodule : coec_core

`default_nettype wire

// >>> hw/coec_defines.svh
/*
  Offsets, field positions, reset values and timing figures of the
  complementary output event control block.
  Assumes one inclusion per compilation unit, guarded below.
*/
`ifndef COEC_DEFINES_SVH
`define COEC_DEFINES_SVH

// Register word indices; the byte address is four times the index.
`define COEC_IDX_CTL0       5'h00
`define COEC_IDX_CTL1       5'h01
`define COEC_IDX_RIS_LO     5'h02
`define COEC_IDX_RIS_HI     5'h03
`define COEC_IDX_FIS_LO     5'h04
`define COEC_IDX_FIS_HI     5'h05
`define COEC_IDX_RSIM_LO    5'h06
`define COEC_IDX_RSIM_HI    5'h07
`define COEC_IDX_FSIM_LO    5'h08
`define COEC_IDX_FSIM_HI    5'h09
`define COEC_IDX_STEER      5'h0a
`define COEC_IDX_DBR        5'h0b
`define COEC_IDX_DBF        5'h0c
`define COEC_IDX_BLKR       5'h0d
`define COEC_IDX_BLKF       5'h0e
`define COEC_IDX_PHR        5'h0f
`define COEC_IDX_PHF        5'h10
`define COEC_IDX_SHUT       5'h11
`define COEC_IDX_STATUS     5'h12
`define COEC_NUM_RW         18
`define COEC_REG_RESET      8'h00

// Field positions.
`define COEC_CTL0_MODE_LSB  0
`define COEC_CTL0_CS_LSB    3
`define COEC_CTL0_RISE_DEADTIME_CHAIN_SEL      5
`define COEC_CTL0_FALL_DEADTIME_CHAIN_SEL      6
`define COEC_CTL0_EN        7
`define COEC_STEER_DATA_LSB 4
`define COEC_SHUT_SW        0
`define COEC_SHUT_OVR_LSB   1

// Timer slots.
`define COEC_TMR_PHR        0
`define COEC_TMR_PHF        1
`define COEC_TMR_BLKR       2
`define COEC_TMR_BLKF       3
`define COEC_TMR_DBR        4
`define COEC_TMR_DBF        5
`define COEC_TMR_COUNT      6

// Timing.
`define COEC_CLK_NS         50
`define COEC_ELEMENT_NS     5
`define COEC_INSTR_LAST     2'h3

`endif

// >>> hw/coec_delay_timer.sv
/*
  Counts delay-clock ticks from zero up to a limit and pulses done.
  Assumes start, stop and tick are synchronous to pclk.
*/
`timescale 1ns/1ps
`default_nettype none

module coec_delay_timer (
  input wire logic    pclk,
  input wire logic    presetn,
  coec_timer_if.timer tmr
);

  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic       next_busy;
  logic       next_done;

  always_comb begin
    next_cnt  = cnt;
    next_busy = tmr.busy;
    next_done = 1'b0;
    if (tmr.stop) begin
      next_busy = 1'b0;
    end else if (tmr.start) begin
      // A zero limit leaves the timer idle; the user passes the event through.
      next_cnt  = 8'h00;
      next_busy = (tmr.limit != 8'h00);
    end else if (tmr.busy && tmr.tick) begin
      next_cnt = cnt + 8'h01;
      if (next_cnt == tmr.limit) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt      <= 8'h00;
      tmr.busy <= 1'b0;
      tmr.done <= 1'b0;
    end else begin
      cnt      <= next_cnt;
      tmr.busy <= next_busy;
      tmr.done <= next_done;
    end
  end

endmodule : coec_delay_timer

`default_nettype wire

// >>> hw/coec_pkg.sv
/*
  Types of the complementary output event control block.
  Assumes coec_defines.svh for numeric constants.
*/
package coec_pkg;

  typedef enum logic [2:0] {
    mode_steer,
    mode_sync_steer,
    mode_full_fwd,
    mode_full_rev,
    mode_half,
    mode_push_pull,
    mode_rsv6,
    mode_rsv7
  } coec_mode_t;

  typedef enum logic [1:0] {
    clk_fast_osc,
    clk_instr,
    clk_system,
    clk_system_alt
  } coec_clk_sel_t;

  typedef enum logic [1:0] {
    ovr_inactive,
    ovr_float,
    ovr_low,
    ovr_high
  } coec_override_t;

endpackage : coec_pkg

// >>> hw/coec_timer_if.sv
/*
  Carrier between the main block and one delay timer.
  Assumes the user side drives start, stop, tick and limit on pclk.
*/
`timescale 1ns/1ps
`default_nettype none

interface coec_timer_if;
  logic       start;
  logic       stop;
  logic       tick;
  logic [7:0] limit;
  logic       busy;
  logic       done;

  modport timer (input start, input stop, input tick, input limit, output busy, output done);
  modport user (output start, output stop, output tick, output limit, input busy, input done);
endinterface : coec_timer_if

`default_nettype wire

// >>> verif/coec_core_assertions.sv
/*
  Port checker for the event control core: output mapping per mode.
  Assumes it is bound to coec_core and shadows writes to four registers.
*/
`timescale 1ns/1ps
`default_nettype none

module coec_core_assertions (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        shutdown_request,
  input wire logic        drive_out_first,
  input wire logic        drive_out_second,
  input wire logic        drive_out_third,
  input wire logic        drive_out_fourth,
  input wire logic [3:0]  drive_out_oe_n
);
  logic [7:0] ctl0, pol, steer, shut;
  logic [2:0] quiet;
  logic [3:0] q, ovr_lvl;
  logic       wr, down, ok;
  assign q = {drive_out_fourth, drive_out_third, drive_out_second, drive_out_first};
  assign wr = psel && penable && pwrite && pready;
  assign down = shut[0] || shutdown_request;
  assign ok = quiet == 3'h7;
  assign ovr_lvl = shut[2] ? {4{shut[1]}} : (shut[1] ? 4'h0 : pol[3:0]);
  // Outputs lag a write by a few cycles, so checks wait until the setup is quiet.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl0 <= 8'h00;
      pol <= 8'h00;
      steer <= 8'h00;
      shut <= 8'h00;
      quiet <= 3'h0;
    end else begin
      if (wr && paddr == 8'h00) ctl0 <= pwdata[7:0];
      if (wr && paddr == 8'h04) pol <= pwdata[7:0];
      if (wr && paddr == 8'h28) steer <= pwdata[7:0];
      if (wr && paddr == 8'h44) shut <= pwdata[7:0];
      if (wr || $changed(shutdown_request)) quiet <= 3'h0;
      else if (!ok) quiet <= quiet + 3'h1;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  pready_high_a: assert property (pready) else $error("pready low");
  bad_addr_a: assert property (psel && penable && paddr > 8'h48 |-> pslverr)
    else $error("unmapped access not refused");
  idle_out_a: assert property (
    ok && !down && !ctl0[7] && ctl0[2:1] != 2'h0 |-> q == pol[3:0])
    else $error("disabled output not inactive");
  steer_data_a: assert property (
    ok && !down && ctl0[2:0] == 3'h0 && steer[3:0] == 4'h0 && pol[3:0] == 4'h0
    |-> q == steer[7:4]) else $error("static steering data wrong");
  ovr_level_a: assert property (ok && down && shut[2:1] != 2'h1 |-> q == ovr_lvl)
    else $error("override level wrong");
  ovr_float_a: assert property (
    ok |-> drive_out_oe_n == ((down && shut[2:1] == 2'h1) ? 4'hf : 4'h0))
    else $error("output enable wrong");
  fwd_bridge_a: assert property (
    ok && !down && ctl0[7] && ctl0[2:0] == 3'h2 |-> q[2:0] == {pol[2], pol[1], ~pol[0]})
    else $error("forward bridge outputs wrong");
  rev_bridge_a: assert property (
    ok && !down && ctl0[7] && ctl0[2:0] == 3'h3
    |-> {q[3], q[2], q[0]} == {pol[3], ~pol[2], pol[0]}) else $error("reverse bridge wrong");
  half_pair_a: assert property (
    ok && !down && ctl0[7] && ctl0[2:0] == 3'h4 && pol[3:0] == 4'h0
    |-> (q[0] == q[2] && q[1] == q[3] && !(q[0] && q[1]))[*2])
    else $error("half bridge pair overlap");
  cover property (ok && ctl0[7] && ctl0[2:0] == 3'h4 && q == 4'h5);
  cover property (ok && down && shut[2:1] == 2'h1);
  cover property (pslverr);
endmodule : coec_core_assertions

bind coec_core coec_core_assertions u_chk (.*);

`default_nettype wire

// >>> verif/coec_switch_model.sv
/*
  Gate inputs of the external switch drivers.
  Assumes pulled-down gate inputs on every output line.
*/
`timescale 1ns/1ps
`default_nettype none

module coec_switch_model (
  input  wire logic [3:0] drv,
  input  wire logic [3:0] oe_n,
  output var  logic [3:0] gate
);
  // A floated line falls to the pull-down, so that switch is off.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      gate[i] = oe_n[i] ? 1'b0 : drv[i];
    end
  end
endmodule : coec_switch_model

`default_nettype wire

// >>> verif/test_complementary_output_event_control.sv
/*
  Testbench of the event control core over APB with event pins.
  Assumes coec_defines.svh for word indices.
*/
`timescale 1ns/1ps
`default_nettype none
`include "coec_defines.svh"

module test_complementary_output_event_control;
  logic        pclk, presetn, psel, penable, pwrite, osc, shut_pin;
  logic        pready, pslverr, err, a, b, c, d;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] src;
  logic [3:0]  q, oe_n, gate;
  logic [3:0]  ovr_exp [4] = '{4'h5, 4'h0, 4'h0, 4'hf};
  int          num_errors, n_checks;
  assign q = {d, c, b, a};

  coec_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .event_source(src), .fast_internal_oscillator(osc),
    .shutdown_request(shut_pin), .drive_out_first(a), .drive_out_second(b),
    .drive_out_third(c), .drive_out_fourth(d), .drive_out_oe_n(oe_n));
  coec_switch_model u_sw (.drv(q), .oe_n(oe_n), .gate(gate));

  always #25 pclk = ~pclk;
  always #31.25 osc = ~osc;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic [4:0] idx, input logic w, input logic [7:0] v);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {1'b0, idx, 2'b00};
    pwdata <= {24'h0, v};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic ev(input logic [15:0] v);
    @(posedge pclk);
    src <= v;
  endtask : ev

  task automatic hold(input int n, input logic [3:0] exp);
    repeat (n) @(negedge pclk);
    chk(32'(q), 32'(exp));
  endtask : hold

  task automatic wait_out(input logic [3:0] exp, input int max);
    int n;
    n = 0;
    while (q !== exp && n < max) begin
      @(negedge pclk);
      n++;
    end
    chk(32'(q), 32'(exp));
  endtask : wait_out

  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    print_verdict();
  end

  initial begin
    {pclk, presetn, psel, penable, pwrite, osc, shut_pin} = 7'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    src = 16'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(`COEC_IDX_CTL0, 1'b0, 8'h00);
    chk(rd, 32'h0);
    apb(`COEC_IDX_CTL1, 1'b1, 8'h05);
    apb(`COEC_IDX_CTL1, 1'b0, 8'h00);
    chk(rd, 32'h5);
    apb(`COEC_IDX_CTL1, 1'b1, 8'h00);
    apb(5'h13, 1'b0, 8'h00);
    chk(32'(err), 32'h1);
    apb(`COEC_IDX_STEER, 1'b1, 8'ha0);
    wait_out(4'ha, 8);
    apb(`COEC_IDX_STEER, 1'b1, 8'h0f);
    wait_out(4'h0, 8);
    apb(`COEC_IDX_RIS_HI, 1'b1, 8'h01);
    apb(`COEC_IDX_FIS_LO, 1'b1, 8'h01);
    apb(`COEC_IDX_FSIM_LO, 1'b1, 8'h01);
    apb(`COEC_IDX_CTL0, 1'b1, 8'h94);
    wait_out(4'ha, 8);
    ev(16'h0100);
    wait_out(4'h5, 12);
    ev(16'h0000);
    hold(10, 4'h5);
    ev(16'h0001);
    hold(10, 4'h5);
    ev(16'h0000);
    wait_out(4'ha, 12);
    apb(`COEC_IDX_DBR, 1'b1, 8'h08);
    ev(16'h0100);
    hold(12, 4'h0);
    wait_out(4'h5, 4);
    apb(`COEC_IDX_DBF, 1'b1, 8'h28);
    apb(`COEC_IDX_CTL0, 1'b1, 8'hd4);
    ev(16'h0101);
    ev(16'h0100);
    hold(8, 4'h0);
    wait_out(4'ha, 12);
    apb(`COEC_IDX_DBR, 1'b1, 8'h02);
    apb(`COEC_IDX_CTL0, 1'b1, 8'h8c);
    ev(16'h0000);
    hold(4, 4'ha);
    ev(16'h0100);
    hold(8, 4'h0);
    wait_out(4'h5, 16);
    apb(`COEC_IDX_CTL0, 1'b1, 8'h92);
    wait_out(4'h9, 8);
    apb(`COEC_IDX_CTL0, 1'b1, 8'h93);
    hold(20, 4'h4);
    wait_out(4'h6, 40);
    apb(`COEC_IDX_CTL1, 1'b1, 8'h05);
    for (int i = 0; i < 4; i++) begin
      apb(`COEC_IDX_SHUT, 1'b1, {5'h0, 2'(i), 1'b1});
      hold(4, ovr_exp[i]);
      chk(32'(oe_n), (i == 1) ? 32'hf : 32'h0);
      chk(32'(gate), 32'(ovr_exp[i]));
    end
    apb(`COEC_IDX_SHUT, 1'b1, 8'h06);
    wait_out(4'h3, 8);
    @(posedge pclk);
    shut_pin <= 1'b1;
    hold(6, 4'hf);
    @(posedge pclk);
    shut_pin <= 1'b0;
    wait_out(4'h3, 10);
    // Push-pull: the pair alternates on every rising event.
    apb(`COEC_IDX_CTL0, 1'b1, 8'h95);
    wait_out(4'hf, 8);
    ev(16'h0000);
    ev(16'h0100);
    wait_out(4'h0, 12);
    // Synchronous steering waits for the next rising event.
    apb(`COEC_IDX_CTL0, 1'b1, 8'h91);
    apb(`COEC_IDX_STEER, 1'b1, 8'h50);
    hold(4, 4'ha);
    ev(16'h0000);
    ev(16'h0100);
    wait_out(4'h0, 12);
    apb(`COEC_IDX_CTL0, 1'b1, 8'h84);
    ev(16'h0000);
    ev(16'h0100);
    wait_out(4'h5, 8);
    wait_out(4'h0, 12);
    apb(`COEC_IDX_CTL0, 1'b1, 8'h04);
    wait_out(4'h5, 8);
    print_verdict();
  end
endmodule : test_complementary_output_event_control

`default_nettype wire
